// File: zcd_defines.vh
// constants for the zero-cross detect control block
`ifndef ZCD_DEFINES_VH
`define ZCD_DEFINES_VH

// apb geometry
`define ZCD_AW              12
`define ZCD_DW              32

// register indices as printed (byte address is four times the index)
`define ZCD_IDX_CTRL        12'h21F
`define ZCD_IDX_STAT        12'h220
`define ZCD_IDX_MASK        12'h221
`define ZCD_IDX_PDIS        12'h222

// byte addresses
`define ZCD_ADDR_CTRL       12'h87C
`define ZCD_ADDR_STAT       12'h880
`define ZCD_ADDR_MASK       12'h884
`define ZCD_ADDR_PDIS       12'h888

// control register fields
`define ZCD_CTRL_SEN        7
`define ZCD_CTRL_OUT        5
`define ZCD_CTRL_INV        4
`define ZCD_CTRL_RISE       1
`define ZCD_CTRL_FALL       0

// status, mask and peripheral disable fields
`define ZCD_STAT_FLAG       0
`define ZCD_PDIS_MD         0

// reset values
`define ZCD_RST_BIT         1'h0
`define ZCD_RST_DATA        32'h0000_0000
`define ZCD_RST_FUSE        1'h1

// fuse capture waits for the synchroniser to settle
`define ZCD_FUSE_SETTLE     2'h3
`define ZCD_CNT_ZERO        2'h0
`define ZCD_CNT_ONE         2'h1

// apb slave states, one-hot
`define ZCD_ST_IDLE         2'h1
`define ZCD_ST_ACC          2'h2

`endif

// File: zcd_sync.v
// two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none

module zcd_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk_sys_i,
	input  wire         rst_i,
	// level from another domain
	input  wire [W-1:0] async_i,
	// synchronised level
	output wire [W-1:0] sync_o
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= {W{1'h0}};
			sync_q <= {W{1'h0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

`default_nettype wire

// File: zcd_ctrl.v
// zero-cross detect control and status logic with apb register access
//
// Functional notes
// - detector and edge interrupt logic keep running in sleep, unchanged.
// - fuse at 0: detector enabled from reset, software enable ignored; here enable rises only once the fuse is caught, a few clocks after reset.
// - fuse at 1: software enable turns detector on or off.
// - module disable bit also turns detector off, but only when fuse is 1.
// - status bit 5 reads 1 while sinking, 0 while sourcing, reversed if inverted.
// - bit 4 inverts the logic output feeding status and edge detectors.
// - rise enable bit 1 sets flag on each low-to-high logic output edge.
// - fall enable bit 0 sets flag on each high-to-low logic output edge.
// - one 8-bit control register at index 0x21F; bits 6,3,2 read zero.
// - software clears flag; an edge arriving during the clear keeps it set.
// - a change of the invert control raises an interrupt event regardless.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "zcd_defines.vh"

module zcd_ctrl (
	// clock and reset
	input  wire                 clk_sys_i,
	input  wire                 rst_i,
	// apb slave
	input  wire                 psel_i,
	input  wire                 penable_i,
	input  wire                 pwrite_i,
	input  wire [`ZCD_AW-1:0]   paddr_i,
	input  wire [`ZCD_DW-1:0]   pwdata_i,
	output wire                 pready_o,
	output wire [`ZCD_DW-1:0]   prdata_o,
	output wire                 pslverr_o,
	// analog comparator and configuration fuse
	input  wire                 comp_sink_i,
	input  wire                 zero_cross_config_fuse_i,
	// detector control and logic output
	output wire                 zcd_enable_o,
	output wire                 zcd_out_o,
	// interrupt
	output wire                 irq_o
);

	// apb slave states, one-hot
	localparam [1:0] ST_IDLE = `ZCD_ST_IDLE;
	localparam [1:0] ST_ACC  = `ZCD_ST_ACC;

	// apb slave state
	reg [1:0]          state_q;
	reg                pready_q;
	reg                pslverr_q;
	reg [`ZCD_DW-1:0]  prdata_q;

	// software visible control bits
	reg                sw_enable_q;
	reg                invert_sense_q;
	reg                rise_irq_en_q;
	reg                fall_irq_en_q;
	reg                module_disable_bit_q;
	reg                irq_mask_q;
	reg                zero_cross_irq_flag_q;

	// fuse capture
	reg                fuse_q;
	reg                fuse_done_q;
	reg [1:0]          fuse_cnt_q;

	// logic output and edge history
	reg                out_q;
	reg                out_prev_q;

	// registered outputs
	reg                enable_q;
	reg                irq_q;

	// combinational
	wire               comp_sync;
	wire               fuse_sync;
	wire               setup_phase;
	wire               access_done;
	wire               wr_done;
	wire               addr_ctrl;
	wire               addr_stat;
	wire               addr_mask;
	wire               addr_pdis;
	wire               addr_hit;
	wire               out_d;
	wire               rise_evt;
	wire               fall_evt;
	wire               inv_evt;
	wire               set_evt;
	wire               clr_flag;
	wire               enable_d;
	wire               inv_d;
	reg [`ZCD_DW-1:0]  rdata_d;

	// comparator level into the clock domain
	zcd_sync #(
		.W(1)
	) u_comp_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   (comp_sink_i),
		.sync_o    (comp_sync)
	);

	// fuse level into the clock domain
	zcd_sync #(
		.W(1)
	) u_fuse_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   (zero_cross_config_fuse_i),
		.sync_o    (fuse_sync)
	);

	// fuse is caught once, after the synchroniser has settled past reset
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			fuse_cnt_q  <= `ZCD_CNT_ZERO;
			fuse_done_q <= `ZCD_RST_BIT;
			fuse_q      <= `ZCD_RST_FUSE;
		end else if (!fuse_done_q) begin
			if (fuse_cnt_q == `ZCD_FUSE_SETTLE) begin
				fuse_q      <= fuse_sync;
				fuse_done_q <= 1'h1;
			end else begin
				fuse_cnt_q <= fuse_cnt_q + `ZCD_CNT_ONE;
			end
		end
	end

	// address decode
	assign addr_ctrl   = (paddr_i == `ZCD_ADDR_CTRL);
	assign addr_stat   = (paddr_i == `ZCD_ADDR_STAT);
	assign addr_mask   = (paddr_i == `ZCD_ADDR_MASK);
	assign addr_pdis   = (paddr_i == `ZCD_ADDR_PDIS);
	assign addr_hit    = addr_ctrl | addr_stat | addr_mask | addr_pdis;

	assign setup_phase = psel_i & ~penable_i;
	assign access_done = psel_i & penable_i & pready_q;
	assign wr_done     = access_done & pwrite_i & addr_hit;

	// read data is gathered in the setup cycle
	always @* begin
		rdata_d = `ZCD_RST_DATA;
		if (addr_ctrl) begin
			rdata_d[`ZCD_CTRL_SEN]  = sw_enable_q;
			rdata_d[`ZCD_CTRL_OUT]  = out_q;
			rdata_d[`ZCD_CTRL_INV]  = invert_sense_q;
			rdata_d[`ZCD_CTRL_RISE] = rise_irq_en_q;
			rdata_d[`ZCD_CTRL_FALL] = fall_irq_en_q;
		end else if (addr_stat) begin
			rdata_d[`ZCD_STAT_FLAG] = zero_cross_irq_flag_q;
		end else if (addr_mask) begin
			rdata_d[`ZCD_STAT_FLAG] = irq_mask_q;
		end else if (addr_pdis) begin
			rdata_d[`ZCD_PDIS_MD]   = module_disable_bit_q;
		end
	end

	// apb slave: one wait-free access cycle after setup
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q   <= ST_IDLE;
			pready_q  <= `ZCD_RST_BIT;
			pslverr_q <= `ZCD_RST_BIT;
			prdata_q  <= `ZCD_RST_DATA;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (setup_phase) begin
						state_q   <= ST_ACC;
						pready_q  <= 1'h1;
						pslverr_q <= ~addr_hit;
						prdata_q  <= pwrite_i ? `ZCD_RST_DATA : rdata_d;
					end
				end
				ST_ACC: begin
					if (access_done || !psel_i) begin
						state_q   <= ST_IDLE;
						pready_q  <= 1'h0;
						pslverr_q <= 1'h0;
						prdata_q  <= `ZCD_RST_DATA;
					end
				end
				default: begin
					state_q   <= ST_IDLE;
					pready_q  <= 1'h0;
					pslverr_q <= 1'h0;
					prdata_q  <= `ZCD_RST_DATA;
				end
			endcase
		end
	end

	// control register; the status bit and unimplemented bits ignore writes
	assign inv_d = (wr_done && addr_ctrl) ? pwdata_i[`ZCD_CTRL_INV] : invert_sense_q;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sw_enable_q    <= `ZCD_RST_BIT;
			invert_sense_q <= `ZCD_RST_BIT;
			rise_irq_en_q  <= `ZCD_RST_BIT;
			fall_irq_en_q  <= `ZCD_RST_BIT;
		end else if (wr_done && addr_ctrl) begin
			sw_enable_q    <= pwdata_i[`ZCD_CTRL_SEN];
			invert_sense_q <= pwdata_i[`ZCD_CTRL_INV];
			rise_irq_en_q  <= pwdata_i[`ZCD_CTRL_RISE];
			fall_irq_en_q  <= pwdata_i[`ZCD_CTRL_FALL];
		end
	end

	// mask and peripheral disable registers
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_mask_q           <= `ZCD_RST_BIT;
			module_disable_bit_q <= `ZCD_RST_BIT;
		end else if (wr_done) begin
			if (addr_mask) begin
				irq_mask_q <= pwdata_i[`ZCD_STAT_FLAG];
			end
			if (addr_pdis) begin
				module_disable_bit_q <= pwdata_i[`ZCD_PDIS_MD];
			end
		end
	end

	// fuse low forces enable; fuse high hands it to software and module disable
	assign enable_d = ~fuse_q | (sw_enable_q & ~module_disable_bit_q);

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			enable_q <= `ZCD_RST_BIT;
		end else begin
			enable_q <= enable_d;
		end
	end

	// logic output: comparator sink level optionally inverted
	assign out_d = comp_sync ^ invert_sense_q;

	// no sleep input: the detector path runs on every clock regardless
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			out_q      <= `ZCD_RST_BIT;
			out_prev_q <= `ZCD_RST_BIT;
		end else begin
			out_q      <= out_d;
			out_prev_q <= out_q;
		end
	end

	// edge detectors on the logic output, after the optional invert
	assign rise_evt = enable_q & rise_irq_en_q &  out_q & ~out_prev_q;
	assign fall_evt = enable_q & fall_irq_en_q & ~out_q &  out_prev_q;
	assign inv_evt  = (inv_d != invert_sense_q);
	assign set_evt  = rise_evt | fall_evt | inv_evt;

	// write one to clear
	assign clr_flag = wr_done & addr_stat & pwdata_i[`ZCD_STAT_FLAG];

	// set wins over a simultaneous clear
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			zero_cross_irq_flag_q <= `ZCD_RST_BIT;
		end else if (set_evt) begin
			zero_cross_irq_flag_q <= 1'h1;
		end else if (clr_flag) begin
			zero_cross_irq_flag_q <= 1'h0;
		end
	end

	// interrupt level
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_q <= `ZCD_RST_BIT;
		end else begin
			irq_q <= (zero_cross_irq_flag_q | set_evt) & ~(clr_flag & ~set_evt) & irq_mask_q;
		end
	end

	// outputs
	assign pready_o     = pready_q;
	assign prdata_o     = prdata_q;
	assign pslverr_o    = pslverr_q;
	assign zcd_enable_o = enable_q;
	assign zcd_out_o    = out_q;
	assign irq_o        = irq_q;

endmodule

`default_nettype wire

// File: zcd_comp_model.sv
// comparator model driving the sink or source level
`timescale 1ns/100ps
`default_nettype none
module zcd_comp_model (
	// clock and requested level
	input  wire logic clk_sys_i,
	input  wire logic sink_req_i,
	// comparator output
	output var  logic comp_sink_o = 1'b0
);
	// the crossing settles one clock after the request
	always @(posedge clk_sys_i) begin
		comp_sink_o <= sink_req_i;
	end
endmodule
`default_nettype wire

// File: zcd_monitor.sv
// assertion checker for the zero-cross control block
`timescale 1ns/100ps
`default_nettype none
module zcd_monitor (
	// clock, reset and apb
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	// detector
	input wire logic        zero_cross_config_fuse_i,
	input wire logic        zcd_enable_o,
	input wire logic        zcd_out_o,
	input wire logic        irq_o
);
	// cycles since reset, saturating
	logic [3:0] age_q;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			age_q <= 4'h0;
		else if (age_q != 4'hF)
			age_q <= age_q + 4'h1;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready");
	ready_in_access_a: assert property (pready_o |-> penable_i && $past(psel_i))
		else $error("stray ready");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("data outside access");
	error_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
		else $error("bad error reply");
	irq_hold_a: assert property (irq_o && !psel_i && !$past(psel_i) |=> irq_o)
		else $error("irq dropped");
	irq_cause_a: assert property ($rose(irq_o) |-> $past(psel_i) || $past(psel_i, 2)
		|| $past(zcd_out_o) != $past(zcd_out_o, 2))
		else $error("irq without cause");
	fuse_on_a: assert property (age_q == 4'hF && !zero_cross_config_fuse_i |-> zcd_enable_o)
		else $error("fuse enable lost");
	enable_cause_a: assert property ($changed(zcd_enable_o) |-> $past(psel_i, 2) || age_q != 4'hF)
		else $error("enable moved alone");
	irq_seen_c: cover property ($rose(irq_o));
	err_seen_c: cover property (pslverr_o);
	fuse_seen_c: cover property (!zero_cross_config_fuse_i && zcd_enable_o);
endmodule
bind zcd_ctrl zcd_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
	.zero_cross_config_fuse_i(zero_cross_config_fuse_i), .zcd_enable_o(zcd_enable_o),
	.zcd_out_o(zcd_out_o), .irq_o(irq_o));
`default_nettype wire

// File: zero_cross_detect_control_bench.sv
// self-checking bench for the zero-cross control block
`timescale 1ns/100ps
`default_nettype none
`include "zcd_defines.vh"
module zero_cross_detect_control_bench;
	logic        clk_sys_i;
	logic        rst_i = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        sink_req = 1'b0;
	logic        fuse = 1'b1;
	logic        er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, comp, en, out, irq;
	int          bad_count = 0;
	int          check_count = 0;
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	zcd_comp_model cm_u (.clk_sys_i(clk_sys_i), .sink_req_i(sink_req), .comp_sink_o(comp));
	zcd_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .comp_sink_i(comp),
		.zero_cross_config_fuse_i(fuse), .zcd_enable_o(en), .zcd_out_o(out), .irq_o(irq));
	task automatic finish_test;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic clr;
		apb(1'b1, `ZCD_ADDR_STAT, 32'h1);
	endtask
	task automatic rst_dut(input logic f);
		rst_i <= 1'b1;
		fuse <= f;
		wt(3);
		rst_i <= 1'b0;
		wt(12);
	endtask
	initial begin
		rst_dut(1'b1);
		rdc(`ZCD_ADDR_CTRL, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, `ZCD_ADDR_CTRL, 32'hFF);
		wt(8);
		rdc(`ZCD_ADDR_CTRL, 32'hB3);
		rdc(`ZCD_ADDR_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test map done");
		apb(1'b1, `ZCD_ADDR_MASK, 32'h1);
		wt(2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h82);
		wt(8);
		clr();
		wt(2);
		chk({31'h0, irq}, 32'h0);
		sink_req <= 1'b1;
		wt(8);
		chk({31'h0, irq}, 32'h1);
		chk({31'h0, out}, 32'h1);
		rdc(`ZCD_ADDR_CTRL, 32'hA2);
		clr();
		sink_req <= 1'b0;
		wt(8);
		rdc(`ZCD_ADDR_STAT, 32'h0);
		$display("test rise done");
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h81);
		sink_req <= 1'b1;
		wt(8);
		rdc(`ZCD_ADDR_STAT, 32'h0);
		sink_req <= 1'b0;
		wt(8);
		rdc(`ZCD_ADDR_STAT, 32'h1);
		clr();
		$display("test fall done");
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h82);
		sink_req <= 1'b1;
		wt(2);
		clr();
		rdc(`ZCD_ADDR_STAT, 32'h1);
		clr();
		sink_req <= 1'b0;
		$display("test race done");
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h10);
		wt(4);
		chk({31'h0, en}, 32'h0);
		chk({31'h0, out}, 32'h1);
		rdc(`ZCD_ADDR_STAT, 32'h1);
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h82);
		wt(8);
		clr();
		chk({31'h0, en}, 32'h1);
		apb(1'b1, `ZCD_ADDR_PDIS, 32'h1);
		wt(2);
		chk({31'h0, en}, 32'h0);
		sink_req <= 1'b1;
		wt(8);
		rdc(`ZCD_ADDR_STAT, 32'h0);
		sink_req <= 1'b0;
		$display("test disable done");
		rst_dut(1'b0);
		chk({31'h0, en}, 32'h1);
		apb(1'b1, `ZCD_ADDR_PDIS, 32'h1);
		apb(1'b1, `ZCD_ADDR_CTRL, 32'h0);
		wt(2);
		chk({31'h0, en}, 32'h1);
		$display("test fuse done");
		finish_test();
	end
endmodule
`default_nettype wire
